//--- include/char_draw_consts.svh
// Constants for the character string draw engine.
// Assumes one 250 MHz clock and a 16-bit register port.
// Summary of operation
// - Command is opcode, pointer low, high, count
// - Normal transparent: 1 gets foreground, 0 skipped
// - Normal opaque: 1 foreground, 0 background
// - Reverse transparent: 0 foreground, 1 skipped
// - Reverse opaque: 1 background, 0 foreground
// - Pixels carry plane mask and logic operation
// - Header top bit set suppresses position advance
// - Trap bit aborts string, sets trap flag
// - Trap leaves remaining count and command pointer
// - Height and width fields hold extent minus one
// - Advance by width plus spacing minus one
// - Clip crossing sets overflow, draws inside only
// - Final position ignores clipping
// - Word mode: font base plus code addresses block
// - Byte mode: lookup word plus base addresses block
// - Pick mode flags pixels inside clip rectangle
// - Scan continues after overflow, count recorded
// - Font opcode selects word or byte lookup
// - Two-bit path and rotation, quarter turns
`ifndef CHAR_DRAW_CONSTS_SVH
`define CHAR_DRAW_CONSTS_SVH
`define OP_MASK 16'hFF00
`define OP_OPAQUE 16'hA600
`define OP_TRANSP 16'hA700
`define OP_RV_OPAQUE 16'hA800
`define OP_RV_TRANSP 16'hA900
`define OP_TRANSP_BIT 8
`define FONT_BYTE_OP 8'h0B
`define WSTEP 22'h000002
`define HDR_S 15
`define HDR_T 7
`define HDR_W 8
`define HDR_H 0
`define C_GO 0
`define C_PICK 1
`define C_PATH 2
`define C_ROT 4
`define ST_BUSY 0
`define ST_OVF 1
`define ST_PICK 2
`define ST_TRAP 3
`define ST_DONE 4
`define ST_BAD 5
`define A_CTRL 5'h00
`define A_STAT 5'h01
`define A_FONT_LO 5'h02
`define A_FONT_HI 5'h03
`define A_FONT_OP 5'h04
`define A_CPTR_LO 5'h05
`define A_CPTR_HI 5'h06
`define A_POS_X 5'h07
`define A_POS_Y 5'h08
`define A_SPACE 5'h09
`define A_FG 5'h0A
`define A_BG 5'h0B
`define A_MASK 5'h0C
`define A_LOP 5'h0D
`define A_XMIN 5'h0E
`define A_XMAX 5'h0F
`define A_YMIN 5'h10
`define A_YMAX 5'h11
`define A_COUNT 5'h12
`endif

//--- include/char_draw_pkg.sv
// Types for the character string draw engine.
// Assumes the constants header is included by the user.
`default_nettype none
package char_draw_pkg;
  typedef enum logic [2:0] {S_IDLE, S_CMD, S_STR, S_TBL, S_HDR, S_ROW, S_PIX, S_ADV} state_t;
  typedef struct packed {
    logic pick; logic [1:0] path; logic [1:0] rot; logic [7:0] fop;
    logic [21:0] font; logic [21:0] cptr; logic [15:0] space;
    logic [7:0] fg; logic [7:0] bg; logic [7:0] mask; logic [3:0] op;
    logic [15:0] xmin; logic [15:0] xmax; logic [15:0] ymin; logic [15:0] ymax;
  } cfg_t;
  typedef struct packed {
    state_t st; logic [1:0] widx; logic [15:0] opc; logic [21:0] sptr;
    logic [15:0] left; logic [15:0] ci; logic [15:0] hdr; logic [15:0] row;
    logic [3:0] r; logic [3:0] c; logic [15:0] x; logic [15:0] y;
    logic ovf; logic pk; logic trap; logic done; logic bad; logic [15:0] rem;
  } eng_t;
  typedef struct packed {
    logic mreq; logic [21:0] maddr; logic pwe; logic [15:0] px; logic [15:0] py;
    logic [7:0] pcol; logic [7:0] pmask; logic [3:0] pop; logic [15:0] rd;
  } out_t;
endpackage : char_draw_pkg
`default_nettype wire

//--- rtl/char_string_draw_engine.sv
// Character string draw engine: fetches command, codes, glyphs; emits pixels.
// Assumes memory answers a held request with a one-cycle ack and data.
`include "char_draw_consts.svh"
`default_nettype none
module char_string_draw_engine (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic mem_req,
  output logic [21:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic pix_we,
  output logic [15:0] pix_x,
  output logic [15:0] pix_y,
  output logic [7:0] pix_color,
  output logic [7:0] pix_plane_mask,
  output logic [3:0] pix_logic_op,
  output logic glyph_trap_flag
);
  char_draw_pkg::cfg_t c_reg, c_next;
  char_draw_pkg::eng_t e_reg, e_next;
  char_draw_pkg::out_t o_reg, o_next;

  // ==========================================================
  // Helpers
  // Offset of a glyph cell point, or of an advance, per quarter turn
  function automatic logic [31:0] rot_off(input logic [1:0] q, input logic [15:0] a,
                                          input logic [15:0] b);
    unique case (q)
      2'h0: rot_off = {a, b};
      2'h1: rot_off = {b, -a};
      2'h2: rot_off = {-a, -b};
      2'h3: rot_off = {-b, a};
    endcase
  endfunction : rot_off

  function automatic logic in_clip(input logic [15:0] x, input logic [15:0] y,
                                   input char_draw_pkg::cfg_t k);
    in_clip = ($signed(x) >= $signed(k.xmin)) && ($signed(x) <= $signed(k.xmax)) &&
              ($signed(y) >= $signed(k.ymin)) && ($signed(y) <= $signed(k.ymax));
  endfunction : in_clip

  // Byte strings share one word per two codes, low byte first
  function automatic logic [21:0] str_addr(input logic [21:0] p, input logic [15:0] i,
                                           input logic bm);
    str_addr = bm ? p + {6'h00, i[15:1], 1'b0} : p + {5'h00, i, 1'b0};
  endfunction : str_addr

  // ==========================================================
  // Datapath terms
  logic busy, go, ack, bytem, rv, transp, op_ok, dot, eff, inc, wr_ok;
  logic [3:0] wf, hf;
  logic [31:0] off, adv;
  logic [15:0] cx, cy, code;

  assign busy = e_reg.st != char_draw_pkg::S_IDLE;
  assign go = reg_wr && reg_addr == `A_CTRL && reg_wdata[`C_GO] && !busy;
  assign ack = mem_ack && o_reg.mreq;
  assign wr_ok = reg_wr && !busy;
  assign bytem = c_reg.fop == `FONT_BYTE_OP;
  assign rv = e_reg.opc == `OP_RV_OPAQUE || e_reg.opc == `OP_RV_TRANSP;
  assign transp = e_reg.opc[`OP_TRANSP_BIT];
  assign op_ok = e_reg.opc == `OP_OPAQUE || e_reg.opc == `OP_TRANSP || rv;
  assign wf = e_reg.hdr[`HDR_W+:4];
  assign hf = e_reg.hdr[`HDR_H+:4];
  assign dot = e_reg.row[wf - e_reg.c];
  assign eff = dot ^ rv;
  assign off = rot_off(c_reg.rot, {12'h000, e_reg.c}, {12'h000, e_reg.r});
  assign cx = e_reg.x + off[31:16];
  assign cy = e_reg.y + off[15:0];
  assign inc = in_clip(cx, cy, c_reg);
  assign adv = rot_off(c_reg.path, {12'h000, wf} + c_reg.space, 16'h0000);
  assign code = bytem ? {8'h00, e_reg.ci[0] ? mem_rdata[15:8] : mem_rdata[7:0]} : mem_rdata;

  // ==========================================================
  // Next state
  always_comb begin
    c_next = c_reg;
    e_next = e_reg;
    o_next = o_reg;
    o_next.pwe = 1'b0;
    o_next.rd = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `A_CTRL: begin
          o_next.rd[`C_PICK] = c_reg.pick;
          o_next.rd[`C_PATH+:2] = c_reg.path;
          o_next.rd[`C_ROT+:2] = c_reg.rot;
        end
        `A_STAT: begin
          o_next.rd[`ST_BUSY] = busy;
          o_next.rd[`ST_OVF] = e_reg.ovf;
          o_next.rd[`ST_PICK] = e_reg.pk;
          o_next.rd[`ST_TRAP] = e_reg.trap;
          o_next.rd[`ST_DONE] = e_reg.done;
          o_next.rd[`ST_BAD] = e_reg.bad;
        end
        `A_FONT_LO: o_next.rd = c_reg.font[15:0];
        `A_FONT_HI: o_next.rd = {10'h000, c_reg.font[21:16]};
        `A_FONT_OP: o_next.rd = {8'h00, c_reg.fop};
        `A_CPTR_LO: o_next.rd = c_reg.cptr[15:0];
        `A_CPTR_HI: o_next.rd = {10'h000, c_reg.cptr[21:16]};
        `A_POS_X: o_next.rd = e_reg.x;
        `A_POS_Y: o_next.rd = e_reg.y;
        `A_SPACE: o_next.rd = c_reg.space;
        `A_FG: o_next.rd = {8'h00, c_reg.fg};
        `A_BG: o_next.rd = {8'h00, c_reg.bg};
        `A_MASK: o_next.rd = {8'h00, c_reg.mask};
        `A_LOP: o_next.rd = {12'h000, c_reg.op};
        `A_XMIN: o_next.rd = c_reg.xmin;
        `A_XMAX: o_next.rd = c_reg.xmax;
        `A_YMIN: o_next.rd = c_reg.ymin;
        `A_YMAX: o_next.rd = c_reg.ymax;
        `A_COUNT: o_next.rd = e_reg.rem;
        default: o_next.rd = 16'h0000;
      endcase
    end
    // Flags clear by writing one; engine sets below win the same cycle
    if (reg_wr && reg_addr == `A_STAT) begin
      e_next.ovf = e_reg.ovf & ~reg_wdata[`ST_OVF];
      e_next.pk = e_reg.pk & ~reg_wdata[`ST_PICK];
      e_next.trap = e_reg.trap & ~reg_wdata[`ST_TRAP];
      e_next.done = e_reg.done & ~reg_wdata[`ST_DONE];
      e_next.bad = e_reg.bad & ~reg_wdata[`ST_BAD];
    end
    // Setup is frozen while a string is being drawn
    if (wr_ok) begin
      unique case (reg_addr)
        `A_CTRL: begin
          c_next.pick = reg_wdata[`C_PICK];
          c_next.path = reg_wdata[`C_PATH+:2];
          c_next.rot = reg_wdata[`C_ROT+:2];
        end
        `A_FONT_LO: c_next.font[15:0] = reg_wdata;
        `A_FONT_HI: c_next.font[21:16] = reg_wdata[5:0];
        `A_FONT_OP: c_next.fop = reg_wdata[7:0];
        `A_CPTR_LO: c_next.cptr[15:0] = reg_wdata;
        `A_CPTR_HI: c_next.cptr[21:16] = reg_wdata[5:0];
        `A_POS_X: e_next.x = reg_wdata;
        `A_POS_Y: e_next.y = reg_wdata;
        `A_SPACE: c_next.space = reg_wdata;
        `A_FG: c_next.fg = reg_wdata[7:0];
        `A_BG: c_next.bg = reg_wdata[7:0];
        `A_MASK: c_next.mask = reg_wdata[7:0];
        `A_LOP: c_next.op = reg_wdata[3:0];
        `A_XMIN: c_next.xmin = reg_wdata;
        `A_XMAX: c_next.xmax = reg_wdata;
        `A_YMIN: c_next.ymin = reg_wdata;
        `A_YMAX: c_next.ymax = reg_wdata;
        default: c_next = c_reg;
      endcase
    end
    unique case (e_reg.st)
      char_draw_pkg::S_IDLE: begin
        if (go) begin
          e_next.st = char_draw_pkg::S_CMD;
          e_next.widx = 2'h0;
          o_next.mreq = 1'b1;
          o_next.maddr = c_reg.cptr;
        end
      end
      char_draw_pkg::S_CMD: begin
        if (ack) begin
          e_next.widx = e_reg.widx + 2'h1;
          o_next.maddr = o_reg.maddr + `WSTEP;
          unique case (e_reg.widx)
            2'h0: e_next.opc = mem_rdata & `OP_MASK;
            2'h1: e_next.sptr[15:0] = mem_rdata;
            2'h2: e_next.sptr[21:16] = mem_rdata[5:0];
            2'h3: begin
              e_next.left = mem_rdata;
              e_next.ci = 16'h0000;
              o_next.maddr = str_addr(e_reg.sptr, 16'h0000, bytem);
              if (!op_ok || mem_rdata == 16'h0000) begin
                e_next.bad = e_reg.bad | !op_ok;
                e_next.done = 1'b1;
                e_next.st = char_draw_pkg::S_IDLE;
                o_next.mreq = 1'b0;
              end else begin
                e_next.st = char_draw_pkg::S_STR;
              end
            end
          endcase
        end
      end
      char_draw_pkg::S_STR: begin
        if (ack) begin
          o_next.maddr = c_reg.font + code;
          e_next.st = bytem ? char_draw_pkg::S_TBL : char_draw_pkg::S_HDR;
        end
      end
      char_draw_pkg::S_TBL: begin
        if (ack) begin
          o_next.maddr = c_reg.font + mem_rdata;
          e_next.st = char_draw_pkg::S_HDR;
        end
      end
      char_draw_pkg::S_HDR: begin
        if (ack) begin
          e_next.hdr = mem_rdata;
          e_next.r = 4'h0;
          o_next.maddr = o_reg.maddr + `WSTEP;
          e_next.st = char_draw_pkg::S_ROW;
          if (mem_rdata[`HDR_T]) begin
            e_next.trap = 1'b1;
            e_next.rem = e_reg.left;
            e_next.done = 1'b1;
            e_next.st = char_draw_pkg::S_IDLE;
            o_next.mreq = 1'b0;
          end
        end
      end
      char_draw_pkg::S_ROW: begin
        if (ack) begin
          e_next.row = mem_rdata;
          e_next.c = 4'h0;
          o_next.mreq = 1'b0;
          e_next.st = char_draw_pkg::S_PIX;
        end
      end
      char_draw_pkg::S_PIX: begin
        // One cell point per cycle; whole box scanned so clip tests see it
        if (inc) begin
          if (c_reg.pick) begin
            e_next.pk = 1'b1;
          end else if (!transp || eff) begin
            o_next.pwe = 1'b1;
            o_next.px = cx;
            o_next.py = cy;
            o_next.pcol = eff ? c_reg.fg : c_reg.bg;
            o_next.pmask = c_reg.mask;
            o_next.pop = c_reg.op;
          end
        end else begin
          e_next.ovf = 1'b1;
          e_next.rem = e_reg.left;
        end
        if (e_reg.c != wf) begin
          e_next.c = e_reg.c + 4'h1;
        end else if (e_reg.r != hf) begin
          e_next.r = e_reg.r + 4'h1;
          o_next.mreq = 1'b1;
          o_next.maddr = o_reg.maddr + `WSTEP;
          e_next.st = char_draw_pkg::S_ROW;
        end else begin
          e_next.st = char_draw_pkg::S_ADV;
        end
      end
      char_draw_pkg::S_ADV: begin
        if (!e_reg.hdr[`HDR_S]) begin
          e_next.x = e_reg.x + adv[31:16];
          e_next.y = e_reg.y + adv[15:0];
        end
        e_next.left = e_reg.left - 16'h0001;
        e_next.ci = e_reg.ci + 16'h0001;
        if (e_reg.left == 16'h0001) begin
          e_next.done = 1'b1;
          e_next.st = char_draw_pkg::S_IDLE;
        end else begin
          o_next.mreq = 1'b1;
          o_next.maddr = str_addr(e_reg.sptr, e_reg.ci + 16'h0001, bytem);
          e_next.st = char_draw_pkg::S_STR;
        end
      end
    endcase
  end

  // ==========================================================
  // State registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      c_reg <= '0;
      e_reg <= '0;
      o_reg <= '0;
    end else begin
      c_reg <= c_next;
      e_reg <= e_next;
      o_reg <= o_next;
    end
  end

  assign reg_rdata = o_reg.rd;
  assign mem_req = o_reg.mreq;
  assign mem_addr = o_reg.maddr;
  assign pix_we = o_reg.pwe;
  assign pix_x = o_reg.px;
  assign pix_y = o_reg.py;
  assign pix_color = o_reg.pcol;
  assign pix_plane_mask = o_reg.pmask;
  assign pix_logic_op = o_reg.pop;
  assign glyph_trap_flag = e_reg.trap;

  // ==========================================================
  // Checks
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_hdr_trap;
    e_reg.st == char_draw_pkg::S_HDR && ack && mem_rdata[`HDR_T];
  endsequence
  sequence s_last_cmd_word;
    e_reg.st == char_draw_pkg::S_CMD && ack && e_reg.widx == 2'h3;
  endsequence

  a_trap_abort: assert property (s_hdr_trap |=> glyph_trap_flag && !busy
    && e_reg.rem == $past(e_reg.left)) else $error("trap did not abort");
  a_zero_count: assert property (s_last_cmd_word ##0 mem_rdata == 16'h0000
    |=> !busy && !mem_req ##1 $stable(e_reg.x) && $stable(e_reg.y))
    else $error("zero count moved or fetched");
  a_pix_clip: assert property (pix_we |-> in_clip(pix_x, pix_y, c_reg))
    else $error("pixel written outside clip");
  a_pix_mask: assert property (pix_we |-> pix_plane_mask == c_reg.mask
    && pix_logic_op == c_reg.op) else $error("pixel mask or op wrong");
  a_transp_skip: assert property (e_reg.st == char_draw_pkg::S_PIX && transp && !eff
    |=> !pix_we) else $error("transparent dot written");
  a_opaque_color: assert property (e_reg.st == char_draw_pkg::S_PIX && inc
    && !c_reg.pick && !transp |=> pix_we && pix_color == ($past(eff) ? c_reg.fg : c_reg.bg))
    else $error("opaque colour wrong");
  a_no_advance: assert property (e_reg.st == char_draw_pkg::S_ADV && e_reg.hdr[`HDR_S]
    |=> $stable(e_reg.x) && $stable(e_reg.y)) else $error("position moved");
  a_path_advance: assert property (e_reg.st == char_draw_pkg::S_ADV
    && !e_reg.hdr[`HDR_S] && c_reg.path == 2'h0
    |=> e_reg.x == $past(e_reg.x) + {12'h000, $past(wf)} + c_reg.space)
    else $error("advance distance wrong");
  a_word_addr: assert property (e_reg.st == char_draw_pkg::S_STR && ack && !bytem
    |=> mem_addr == c_reg.font + $past(mem_rdata)) else $error("word lookup wrong");
  a_byte_addr: assert property (e_reg.st == char_draw_pkg::S_TBL && ack
    |=> mem_addr == c_reg.font + $past(mem_rdata)) else $error("byte lookup wrong");
  a_pick_flag: assert property (e_reg.st == char_draw_pkg::S_PIX && inc && c_reg.pick
    |=> e_reg.pk && !pix_we) else $error("pick flag missed");
  a_overflow: assert property (e_reg.st == char_draw_pkg::S_PIX && !inc
    |=> e_reg.ovf && e_reg.rem == $past(e_reg.left)) else $error("overflow missed");
endmodule : char_string_draw_engine
`default_nettype wire

//--- verification/glyph_memory_model.sv
// Behavioural system memory holding commands, strings, fonts and glyphs.
// Assumes held requests from the engine; answers with a one-cycle ack.
`default_nettype none
module glyph_memory_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic [21:0] mem_addr,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Storage, word addressed, filled by the bench
  logic [15:0] words [4096];
  logic [1:0] wait_cnt;
  // ==========================================
  // Answer
  // Data lines invert when idle so stale data never looks valid
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0000;
      wait_cnt <= 2'h0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_cnt <= 2'h0;
    end else if (mem_req && (!slow || wait_cnt == 2'h3)) begin
      mem_ack <= 1'b1;
      mem_rdata <= words[mem_addr[12:1]];
    end else begin
      mem_rdata <= ~mem_rdata;
      wait_cnt <= mem_req ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule : glyph_memory_model
`default_nettype wire

//--- verification/tb_top.sv
// Bench for the character string draw engine.
// Assumes the memory model and register indices from the constants header.
`include "char_draw_consts.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic slow = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, mem_rdata, pix_x, pix_y, rd_val;
  logic [15:0] last_x = 16'h0000;
  logic [15:0] last_y = 16'h0000;
  logic mem_req, mem_ack, pix_we, glyph_trap_flag;
  logic [21:0] mem_addr;
  logic [7:0] pix_color, pix_plane_mask;
  logic [3:0] pix_logic_op;
  int miscompares = 0;
  int check_count = 0;
  int fg_n, bg_n, attr_bad;
  logic [20:0] cfg [15] = '{{`A_FONT_LO, 16'h1000}, {`A_FONT_HI, 16'h0000},
    {`A_FONT_OP, 16'h000A}, {`A_CPTR_LO, 16'h0100}, {`A_CPTR_HI, 16'h0000},
    {`A_SPACE, 16'h0003}, {`A_FG, 16'h005A}, {`A_BG, 16'h00C3}, {`A_MASK, 16'h003C},
    {`A_LOP, 16'h0006}, {`A_XMIN, 16'h0000}, {`A_XMAX, 16'h00FF},
    {`A_YMIN, 16'h0000}, {`A_YMAX, 16'h00FF}, {`A_CTRL, 16'h0000}};
  logic [15:0] ops [4] = '{`OP_OPAQUE, `OP_TRANSP, `OP_RV_OPAQUE, `OP_RV_TRANSP};
  int exp_fg [4] = '{3, 3, 1, 1};
  int exp_bg [4] = '{1, 0, 3, 0};
  always #2 sys_clk = ~sys_clk;
  char_string_draw_engine uut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .pix_we(pix_we), .pix_x(pix_x), .pix_y(pix_y), .pix_color(pix_color),
    .pix_plane_mask(pix_plane_mask), .pix_logic_op(pix_logic_op),
    .glyph_trap_flag(glyph_trap_flag));
  glyph_memory_model mem0 (.sys_clk(sys_clk), .resetn(resetn), .slow(slow),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // ==========================================
  // Pixel monitor
  always @(posedge sys_clk) begin
    if (pix_we === 1'b1) begin
      last_x <= pix_x;
      last_y <= pix_y;
      if (pix_color === 8'h5A) fg_n <= fg_n + 1;
      else if (pix_color === 8'hC3) bg_n <= bg_n + 1;
      if (pix_plane_mask !== 8'h3C || pix_logic_op !== 4'h6) attr_bad <= attr_bad + 1;
    end
  end
  // ==========================================
  // Tasks
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd
  task automatic check(input string name, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask : check
  task automatic chk_reg(input string name, input logic [4:0] a, input logic [15:0] e);
    rd(a);
    check(name, e, rd_val);
  endtask : chk_reg
  task automatic chk_stat(input string name, input int b, input logic e);
    rd(`A_STAT);
    check(name, {15'h0000, e}, {15'h0000, rd_val[b]});
  endtask : chk_stat
  // Command at byte 0x100, string at byte 0x200; reserved bits and end bit zero
  task automatic run(input logic [15:0] opc, input logic [15:0] cnt, input logic [15:0] ctl);
    int i;
    mem0.words[12'h080] = opc;
    mem0.words[12'h081] = 16'h0200;
    mem0.words[12'h082] = 16'h0000;
    mem0.words[12'h083] = cnt;
    wr(`A_STAT, 16'h003E);
    wr(`A_POS_X, 16'h000A);
    wr(`A_POS_Y, 16'h000A);
    fg_n = 0;
    bg_n = 0;
    attr_bad = 0;
    wr(`A_CTRL, ctl | 16'h0001);
    for (i = 0; i < 300; i++) begin
      rd(`A_STAT);
      if (rd_val[`ST_DONE] === 1'b1) break;
    end
    if (i == 300) begin
      miscompares++;
      $display("CHECK FAILED done expected 1 seen 0");
      end_of_test();
    end
    $display("Test opcode %h count %0d finished", opc, cnt);
  endtask : run
  // ==========================================
  // Sequence
  initial begin
    // Glyphs: 2x2, rows 01 and 11; plain, no-advance, trap
    mem0.words[12'h810] = 16'h0101;
    mem0.words[12'h820] = 16'h8101;
    mem0.words[12'h830] = 16'h0181;
    for (int g = 0; g < 3; g++) begin
      mem0.words[12'h811 + 12'h010 * g] = 16'h0001;
      mem0.words[12'h812 + 12'h010 * g] = 16'h0003;
    end
    mem0.words[12'h802] = 16'h0020;
    mem0.words[12'h803] = 16'h0040;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    chk_reg("status_reset", `A_STAT, 16'h0000);
    chk_reg("count_reset", `A_COUNT, 16'h0000);
    chk_reg("unmapped", 5'h1F, 16'h0000);
    for (int k = 0; k < 15; k++) wr(cfg[k][20:16], cfg[k][15:0]);
    mem0.words[12'h100] = 16'h0020;
    run(`OP_OPAQUE, 16'h0000, 16'h0000);
    check("zero_count_pixels", 16'h0000, 16'(fg_n + bg_n));
    chk_reg("zero_count_pos", `A_POS_X, 16'h000A);
    // Unknown opcode: flagged, nothing drawn
    run(16'hA500, 16'h0001, 16'h0000);
    chk_stat("bad_opcode", `ST_BAD, 1'b1);
    check("bad_op_pixels", 16'h0000, 16'(fg_n + bg_n));
    for (int m = 0; m < 4; m++) begin
      slow <= m[0];
      run(ops[m], 16'h0001, 16'h0000);
      check("fg_count", 16'(exp_fg[m]), 16'(fg_n));
      check("bg_count", 16'(exp_bg[m]), 16'(bg_n));
      check("attr", 16'h0000, 16'(attr_bad));
      chk_reg("advance", `A_POS_X, 16'h000E);
    end
    mem0.words[12'h100] = 16'h0040;
    run(`OP_TRANSP, 16'h0001, 16'h0000);
    chk_reg("no_advance", `A_POS_X, 16'h000A);
    mem0.words[12'h100] = 16'h0020;
    run(`OP_TRANSP, 16'h0001, 16'h0004);
    chk_reg("path_y", `A_POS_Y, 16'h0006);
    // Quarter turn: cell (1,1) lands one column right of and one row above the start point
    run(`OP_TRANSP, 16'h0001, 16'h0010);
    check("rot_pix_x", 16'h000B, last_x);
    check("rot_pix_y", 16'h0009, last_y);
    mem0.words[12'h101] = 16'h0060;
    mem0.words[12'h102] = 16'h0020;
    run(`OP_TRANSP, 16'h0003, 16'h0000);
    check("trap_pin", 16'h0001, {15'h0000, glyph_trap_flag});
    chk_stat("trap_stat", `ST_TRAP, 1'b1);
    check("trap_pixels", 16'h0003, 16'(fg_n));
    chk_reg("trap_count", `A_COUNT, 16'h0002);
    chk_reg("trap_cptr", `A_CPTR_LO, 16'h0100);
    wr(`A_STAT, 16'h003E);
    // Flag falls at the edge that takes the write; look one edge later
    @(posedge sys_clk);
    check("trap_clear", 16'h0000, {15'h0000, glyph_trap_flag});
    mem0.words[12'h101] = 16'h0020;
    // Clip right edge at x=10: first glyph half drawn, second outside
    wr(`A_XMAX, 16'h000A);
    run(`OP_OPAQUE, 16'h0002, 16'h0000);
    check("clip_pixels", 16'h0002, 16'(fg_n + bg_n));
    check("clip_last_x", 16'h000A, last_x);
    check("clip_last_y", 16'h000B, last_y);
    chk_stat("clip_ovf", `ST_OVF, 1'b1);
    chk_reg("clip_pos", `A_POS_X, 16'h0012);
    chk_reg("clip_count", `A_COUNT, 16'h0001);
    run(`OP_OPAQUE, 16'h0002, 16'h0002);
    check("pick_pixels", 16'h0000, 16'(fg_n + bg_n));
    chk_stat("pick_flag", `ST_PICK, 1'b1);
    wr(`A_XMAX, 16'h00FF);
    // Byte mode: low byte selects plain glyph, high byte the no-advance one
    wr(`A_FONT_OP, {8'h00, `FONT_BYTE_OP});
    mem0.words[12'h100] = 16'h0604;
    run(`OP_TRANSP, 16'h0002, 16'h0000);
    check("byte_pixels", 16'h0006, 16'(fg_n));
    chk_reg("byte_pos", `A_POS_X, 16'h000E);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
